// File: smbcfg_params.svh
// Constants of the bus-control block: field positions, reset values, timing.
// Assumes a 20 MHz system clock; included by bare name where needed.
`ifndef SMBCFG_PARAMS_SVH
`define SMBCFG_PARAMS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SMBCFG_CLK_PERIOD_NS    50
`define SMBCFG_PRESC_UNIT_NS    32
`define SMBCFG_GLITCH_NORM_NS   1000
`define SMBCFG_GLITCH_SFAST_NS  200
`define SMBCFG_GLITCH_MFAST_NS  100
`define SMBCFG_CYC_UP(ns)       (((ns) + `SMBCFG_CLK_PERIOD_NS - 1) / `SMBCFG_CLK_PERIOD_NS)
`define SMBCFG_GLITCH_NORM_CYC  5'(`SMBCFG_CYC_UP(`SMBCFG_GLITCH_NORM_NS))
`define SMBCFG_GLITCH_SFAST_CYC 5'(`SMBCFG_CYC_UP(`SMBCFG_GLITCH_SFAST_NS))
`define SMBCFG_GLITCH_MFAST_CYC 5'(`SMBCFG_CYC_UP(`SMBCFG_GLITCH_MFAST_NS))
`define SMBCFG_GLITCH_OFF_CYC   5'h00

// ---------------------------------------------------------------
// Control register fields and reset values
// ---------------------------------------------------------------
`define SMBCFG_PRESC_MSB        15
`define SMBCFG_PRESC_LSB        0
`define SMBCFG_IOM_BIT          16
`define SMBCFG_ICK_BIT          17
`define SMBCFG_SMODE_MSB        19
`define SMBCFG_SMODE_LSB        18
`define SMBCFG_MMODE_MSB        21
`define SMBCFG_MMODE_LSB        20
`define SMBCFG_PRESC_SLOW       16'h0139
`define SMBCFG_PRESC_FAST       16'h0053
`define SMBCFG_PRESC_STOP_MAX   16'h0001
`define SMBCFG_BIT_RST          1'b0
`define SMBCFG_MODE_RST         2'h0

// ---------------------------------------------------------------
// Serial memory start-up
// ---------------------------------------------------------------
`define SMBCFG_EE_ADDR_HI       3'h5
`define SMBCFG_EE_START         16'h0000
`define SMBCFG_EE_MODE_MASK     16'h00aa

`endif

// File: smbcfg_pkg.sv
// Types shared by the bus-control block.
// Assumes nothing beyond the constants header.
package smbcfg_pkg;

	typedef enum logic [1:0]
	{
		SMBCFG_GM_NORMAL = 2'h0,
		SMBCFG_GM_FAST   = 2'h1,
		SMBCFG_GM_OFF    = 2'h2,
		SMBCFG_GM_RSVD   = 2'h3
	} smbcfg_gmode_t;

	typedef enum logic [1:0]
	{
		SMBCFG_CK_STOP = 2'b00,
		SMBCFG_CK_HIGH = 2'b01,
		SMBCFG_CK_LOW  = 2'b11
	} smbcfg_ckst_t;

	typedef logic [4:0] smbcfg_dly_t;

endpackage

// File: smbcfg_flt_if.sv
// Link between the control block and one line glitch filter.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface smbcfg_flt_if;
	logic                    raw;
	smbcfg_pkg::smbcfg_dly_t dly;
	logic                    filt;
	modport src (output raw, output dly, input filt);
	modport flt (input raw, input dly, output filt);
endinterface

// File: smbcfg_glitch.sv
// Glitch filter for one bus line: output follows input once stable long enough.
// Assumes input synchronous to clk_sys; delay of zero passes the line in one cycle.
`timescale 1ns/1ps
module smbcfg_glitch
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Line
	smbcfg_flt_if.flt f
);
	import smbcfg_pkg::*;

	smbcfg_dly_t cnt_r;
	logic        filt_r;

	// ---------------------------------------------------------------
	// Stability counter
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_r  <= 5'h00;
			filt_r <= 1'b1;
		end
		else if (f.raw == filt_r)
			cnt_r <= 5'h00;
		else if ((cnt_r + 5'h01) >= f.dly)
		begin
			cnt_r  <= 5'h00;
			filt_r <= f.raw;
		end
		else
			cnt_r <= cnt_r + 5'h01;
	end

	assign f.filt = filt_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_flt_move;
		@(posedge clk_sys) disable iff (!resetn)
		(f.raw != filt_r) && ((cnt_r + 5'h01) < f.dly) |=> $stable(filt_r);
	endproperty
	a_flt_move: assert property (p_flt_move) else $error("filter output moved early");

endmodule

// File: smbcfg_top.sv
// Bus-control block: master clock prescaler, override bits, glitch filters, start-up.
// Assumes straps and pins are synchronous to clk_sys; resetn is the fundamental reset.
`timescale 1ns/1ps
`include "smbcfg_params.svh"
module smbcfg_top
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Straps
	input  wire logic        master_slow_mode_strap,
	input  wire logic [3:0]  switch_operating_mode,
	input  wire logic [4:1]  eeprom_address_straps,
	// Control register port
	input  wire logic        reg_wr_en,
	input  wire logic [31:0] reg_wr_data,
	output logic      [31:0] reg_rd_data,
	// Master engine
	input  wire logic        arb_lost,
	input  wire logic        cksum_fail,
	input  wire logic        byte_done,
	input  wire logic        load_done,
	output logic             arb_abort,
	output logic             cksum_err,
	output logic             eeprom_load_req,
	output logic      [7:1]  eeprom_dev_addr,
	output logic      [15:0] eeprom_byte_addr,
	// Bus pins
	input  wire logic        master_bus_clock_pin_in,
	output logic             master_bus_clock_pin_out,
	output logic             master_bus_clock_pin_oe,
	input  wire logic        master_bus_data_pin_in,
	input  wire logic        slave_bus_clock_pin_in,
	input  wire logic        slave_bus_data_pin_in,
	// Filtered lines
	output logic             master_clk_filt,
	output logic             master_dat_filt,
	output logic             slave_clk_filt,
	output logic             slave_dat_filt
);
	import smbcfg_pkg::*;

	logic [15:0]   presc_r;
	logic [15:0]   act_presc_r;
	logic          iom_r;
	logic          ick_r;
	smbcfg_gmode_t smode_r;
	smbcfg_gmode_t mmode_r;
	logic          init_done_r;
	smbcfg_ckst_t  ck_st_r;
	logic [20:0]   acc_r;
	logic [20:0]   acc_nxt;
	logic [20:0]   half_ns;
	logic [31:0]   rd_r;
	logic          abort_r;
	logic          ckerr_r;
	logic          load_r;
	logic [7:1]    dev_r;
	logic [15:0]   byte_r;
	logic          oe_r;
	logic          pin_out_r;
	smbcfg_dly_t   sdly;
	smbcfg_dly_t   mdly;

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			presc_r     <= `SMBCFG_PRESC_FAST;
			iom_r       <= `SMBCFG_BIT_RST;
			ick_r       <= `SMBCFG_BIT_RST;
			smode_r     <= SMBCFG_GM_NORMAL;
			mmode_r     <= SMBCFG_GM_NORMAL;
			init_done_r <= 1'b0;
		end
		else if (!init_done_r)
		begin
			init_done_r <= 1'b1;
			presc_r     <= master_slow_mode_strap ? `SMBCFG_PRESC_SLOW
				: `SMBCFG_PRESC_FAST;
		end
		else if (reg_wr_en)
		begin
			presc_r <= reg_wr_data[`SMBCFG_PRESC_MSB:`SMBCFG_PRESC_LSB];
			iom_r   <= reg_wr_data[`SMBCFG_IOM_BIT];
			ick_r   <= reg_wr_data[`SMBCFG_ICK_BIT];
			smode_r <= smbcfg_gmode_t'(reg_wr_data[`SMBCFG_SMODE_MSB:`SMBCFG_SMODE_LSB]);
			mmode_r <= smbcfg_gmode_t'(reg_wr_data[`SMBCFG_MMODE_MSB:`SMBCFG_MMODE_LSB]);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rd_r <= 32'h0000_0000;
		else
			rd_r <= {10'h000, mmode_r, smode_r, ick_r, iom_r, presc_r};
	end

	// ---------------------------------------------------------------
	// Master clock prescaler
	// ---------------------------------------------------------------
	assign half_ns = 21'(act_presc_r) * 21'(`SMBCFG_PRESC_UNIT_NS / 2);
	assign acc_nxt = acc_r + 21'(`SMBCFG_CLK_PERIOD_NS);

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ck_st_r     <= SMBCFG_CK_STOP;
			act_presc_r <= `SMBCFG_PRESC_FAST;
			acc_r       <= 21'h0;
			oe_r        <= 1'b0;
		end
		else
		begin
			unique case (ck_st_r)
				SMBCFG_CK_STOP:
				begin
					acc_r <= 21'h0;
					if (init_done_r && presc_r > `SMBCFG_PRESC_STOP_MAX)
					begin
						act_presc_r <= presc_r;
						ck_st_r     <= SMBCFG_CK_HIGH;
					end
				end
				SMBCFG_CK_HIGH:
				begin
					if (presc_r <= `SMBCFG_PRESC_STOP_MAX)
						ck_st_r <= SMBCFG_CK_STOP;
					else if (acc_nxt >= half_ns)
					begin
						acc_r   <= 21'h0;
						oe_r    <= 1'b1;
						ck_st_r <= SMBCFG_CK_LOW;
					end
					else
						acc_r <= acc_nxt;
				end
				SMBCFG_CK_LOW:
				begin
					if (acc_nxt >= half_ns)
					begin
						acc_r       <= 21'h0;
						oe_r        <= 1'b0;
						act_presc_r <= presc_r;
						ck_st_r     <= (presc_r <= `SMBCFG_PRESC_STOP_MAX)
							? SMBCFG_CK_STOP : SMBCFG_CK_HIGH;
					end
					else
						acc_r <= acc_nxt;
				end
				default:
					ck_st_r <= SMBCFG_CK_STOP;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			pin_out_r <= 1'b0;
		else
			pin_out_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Override bits
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			abort_r <= 1'b0;
			ckerr_r <= 1'b0;
		end
		else
		begin
			abort_r <= arb_lost & ~iom_r;
			ckerr_r <= cksum_fail & ~ick_r;
		end
	end

	// ---------------------------------------------------------------
	// Serial memory start-up
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			load_r <= 1'b0;
			dev_r  <= 7'h00;
			byte_r <= `SMBCFG_EE_START;
		end
		else if (!init_done_r)
		begin
			load_r <= 1'(`SMBCFG_EE_MODE_MASK >> switch_operating_mode);
			dev_r  <= {`SMBCFG_EE_ADDR_HI, eeprom_address_straps};
			byte_r <= `SMBCFG_EE_START;
		end
		else if (load_r)
		begin
			if (load_done)
				load_r <= 1'b0;
			if (byte_done)
				byte_r <= byte_r + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Glitch filters
	// ---------------------------------------------------------------
	always_comb
	begin
		unique case (smode_r)
			SMBCFG_GM_FAST: sdly = `SMBCFG_GLITCH_SFAST_CYC;
			SMBCFG_GM_OFF:  sdly = `SMBCFG_GLITCH_OFF_CYC;
			default:        sdly = `SMBCFG_GLITCH_NORM_CYC;
		endcase
		unique case (mmode_r)
			SMBCFG_GM_FAST: mdly = `SMBCFG_GLITCH_MFAST_CYC;
			SMBCFG_GM_OFF:  mdly = `SMBCFG_GLITCH_OFF_CYC;
			default:        mdly = `SMBCFG_GLITCH_NORM_CYC;
		endcase
	end

	smbcfg_flt_if mck_if ();
	smbcfg_flt_if mdt_if ();
	smbcfg_flt_if sck_if ();
	smbcfg_flt_if sdt_if ();

	assign mck_if.raw = master_bus_clock_pin_in;
	assign mck_if.dly = mdly;
	assign mdt_if.raw = master_bus_data_pin_in;
	assign mdt_if.dly = mdly;
	assign sck_if.raw = slave_bus_clock_pin_in;
	assign sck_if.dly = sdly;
	assign sdt_if.raw = slave_bus_data_pin_in;
	assign sdt_if.dly = sdly;

	smbcfg_glitch u_mck (.clk_sys(clk_sys), .resetn(resetn), .f(mck_if.flt));
	smbcfg_glitch u_mdt (.clk_sys(clk_sys), .resetn(resetn), .f(mdt_if.flt));
	smbcfg_glitch u_sck (.clk_sys(clk_sys), .resetn(resetn), .f(sck_if.flt));
	smbcfg_glitch u_sdt (.clk_sys(clk_sys), .resetn(resetn), .f(sdt_if.flt));

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rd_data              = rd_r;
	assign arb_abort                = abort_r;
	assign cksum_err                = ckerr_r;
	assign eeprom_load_req          = load_r;
	assign eeprom_dev_addr          = dev_r;
	assign eeprom_byte_addr         = byte_r;
	assign master_bus_clock_pin_out = pin_out_r;
	assign master_bus_clock_pin_oe  = oe_r;
	assign master_clk_filt          = mck_if.filt;
	assign master_dat_filt          = mdt_if.filt;
	assign slave_clk_filt           = sck_if.filt;
	assign slave_dat_filt           = sdt_if.filt;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	logic [15:0] low_cnt_r;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			low_cnt_r <= 16'h0000;
		else if (oe_r)
			low_cnt_r <= low_cnt_r + 16'h0001;
		else
			low_cnt_r <= 16'h0000;
	end

	sequence s_release;
		!init_done_r ##1 init_done_r;
	endsequence
	sequence s_period_start;
		(ck_st_r == SMBCFG_CK_LOW) ##1 (ck_st_r == SMBCFG_CK_HIGH);
	endsequence

	property p_stop;
		(ck_st_r == SMBCFG_CK_HIGH) && (presc_r <= `SMBCFG_PRESC_STOP_MAX)
			|=> (ck_st_r == SMBCFG_CK_STOP) && !oe_r;
	endproperty
	a_stop: assert property (p_stop) else $error("clock not stopped");

	property p_low_min;
		$fell(oe_r) |-> 32'(low_cnt_r) * 32'(`SMBCFG_CLK_PERIOD_NS)
			>= 32'($past(act_presc_r)) * 32'(`SMBCFG_PRESC_UNIT_NS / 2);
	endproperty
	a_low_min: assert property (p_low_min) else $error("low phase too short");

	property p_period;
		$fell(oe_r) |-> 32'(low_cnt_r) * 32'(`SMBCFG_CLK_PERIOD_NS)
			< 32'($past(act_presc_r)) * 32'(`SMBCFG_PRESC_UNIT_NS / 2)
			+ 32'(`SMBCFG_CLK_PERIOD_NS);
	endproperty
	a_period: assert property (p_period) else $error("low phase too long");

	property p_strap;
		s_release |-> presc_r == ($past(master_slow_mode_strap)
			? `SMBCFG_PRESC_SLOW : `SMBCFG_PRESC_FAST);
	endproperty
	a_strap: assert property (p_strap) else $error("wrong prescale default");

	property p_iom;
		arb_lost |=> arb_abort == !$past(iom_r);
	endproperty
	a_iom: assert property (p_iom) else $error("arbitration override wrong");

	property p_ick;
		ick_r ##1 ick_r |-> !cksum_err;
	endproperty
	a_ick: assert property (p_ick) else $error("checksum error while ignored");

	property p_ee_load;
		s_release |-> (load_r == 1'(`SMBCFG_EE_MODE_MASK >> $past(switch_operating_mode)))
			&& (byte_r == `SMBCFG_EE_START);
	endproperty
	a_ee_load: assert property (p_ee_load) else $error("load decision wrong");

	property p_ee_addr;
		init_done_r |-> dev_r[7:5] == `SMBCFG_EE_ADDR_HI;
	endproperty
	a_ee_addr: assert property (p_ee_addr) else $error("device address wrong");

	property p_byte_seq;
		init_done_r && load_r && byte_done |=> byte_r == $past(byte_r) + 16'h0001;
	endproperty
	a_byte_seq: assert property (p_byte_seq) else $error("byte address not sequential");

	property p_new_val;
		s_period_start |-> act_presc_r == $past(presc_r);
	endproperty
	a_new_val: assert property (p_new_val) else $error("prescale not reloaded");

	property p_mdly;
		(mmode_r == SMBCFG_GM_OFF) |-> mdly == 5'h00 && sdly != 5'h01;
	endproperty
	a_mdly: assert property (p_mdly) else $error("master filter delay wrong");

endmodule

// File: smbcfg_ee_model.sv
// Serial memory stand-in on the master bus: hands over bytes while a load is wanted.
// Assumes the block's engine strobes come from here and the clock line has a pull-up.
`timescale 1ns/1ps
module smbcfg_ee_model
#(
	parameter int NBYTES = 6,
	parameter int GAP    = 3
)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Block side
	input  wire logic eeprom_load_req,
	input  wire logic clk_oe,
	input  wire logic clk_out,
	output logic      byte_done,
	output logic      load_done,
	// Wire level
	output logic      clk_line
);
	int gap_r;
	int cnt_r;

	// Open-drain clock line, pulled up when released
	assign clk_line = clk_oe ? clk_out : 1'b1;

	// Bytes answered one by one, slowly, from address zero
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			gap_r     <= 0;
			cnt_r     <= 0;
			byte_done <= 1'b0;
			load_done <= 1'b0;
		end
		else
		begin
			byte_done <= 1'b0;
			load_done <= 1'b0;
			if (eeprom_load_req && !load_done)
			begin
				if (gap_r == GAP - 1)
				begin
					gap_r <= 0;
					if (cnt_r == NBYTES)
						load_done <= 1'b1;
					else
					begin
						byte_done <= 1'b1;
						cnt_r     <= cnt_r + 1;
					end
				end
				else
					gap_r <= gap_r + 1;
			end
		end
	end
endmodule

// File: tb_top.sv
// Self-checking bench of the bus-control block with a serial memory stand-in.
// Assumes a 20 MHz clock; inputs change 2 ns after the rising edge.
`timescale 1ns/1ps
`include "smbcfg_params.svh"
module tb_top;
	import smbcfg_pkg::*;
	typedef struct
	{
		logic [31:0] wd;
		logic [31:0] rd;
		logic        ab;
		logic        ce;
	} smbcfg_row_t;
	localparam int          NB         = 6;
	localparam logic [15:0] LOAD_MODES = `SMBCFG_EE_MODE_MASK;
	localparam int          SD [4]     = '{20, 4, 0, 20};
	localparam int          MD [4]     = '{20, 2, 0, 20};
	logic        clk_sys, resetn, slow, wr_en, arb_lost, cksum_fail;
	logic        md_in, sc_in, sd_in, arb_abort, cksum_err, load_req;
	logic        ck_out, ck_oe, ck_line, byte_done, load_done;
	logic        mc_f, md_f, sc_f, sd_f;
	logic [3:0]  mode, addr;
	logic [31:0] wr_data, rd_data;
	logic [7:1]  dev_addr;
	logic [15:0] byte_addr;
	int          failures, num_checks, n;
	smbcfg_row_t rows [5] = '{
		'{32'h0001_0053, 32'h0001_0053, 1'b0, 1'b1},
		'{32'h0002_0053, 32'h0002_0053, 1'b1, 1'b0},
		'{32'hffff_0053, 32'h003f_0053, 1'b0, 1'b0},
		'{32'h0000_0053, 32'h0000_0053, 1'b1, 1'b1},
		'{32'h0024_0053, 32'h0024_0053, 1'b1, 1'b1}};

	smbcfg_top i_smbcfg_top (.clk_sys(clk_sys), .resetn(resetn),
		.master_slow_mode_strap(slow), .switch_operating_mode(mode),
		.eeprom_address_straps(addr), .reg_wr_en(wr_en), .reg_wr_data(wr_data),
		.reg_rd_data(rd_data), .arb_lost(arb_lost), .cksum_fail(cksum_fail),
		.byte_done(byte_done), .load_done(load_done), .arb_abort(arb_abort),
		.cksum_err(cksum_err), .eeprom_load_req(load_req), .eeprom_dev_addr(dev_addr),
		.eeprom_byte_addr(byte_addr), .master_bus_clock_pin_in(ck_line),
		.master_bus_clock_pin_out(ck_out), .master_bus_clock_pin_oe(ck_oe),
		.master_bus_data_pin_in(md_in), .slave_bus_clock_pin_in(sc_in),
		.slave_bus_data_pin_in(sd_in), .master_clk_filt(mc_f), .master_dat_filt(md_f),
		.slave_clk_filt(sc_f), .slave_dat_filt(sd_f));

	smbcfg_ee_model #(.NBYTES(NB), .GAP(3)) i_smbcfg_ee_model (.clk_sys(clk_sys),
		.resetn(resetn), .eeprom_load_req(load_req), .clk_oe(ck_oe), .clk_out(ck_out),
		.byte_done(byte_done), .load_done(load_done), .clk_line(ck_line));

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi)
		begin
			failures++;
			$display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask

	task automatic wr(input logic [31:0] d);
		wr_en = 1'b1;
		wr_data = d;
		tick(1);
		wr_en = 1'b0;
		tick(1);
	endtask

	task automatic do_reset(input logic s, input logic [3:0] m, input logic [3:0] a);
		resetn = 1'b0;
		slow = s;
		mode = m;
		addr = a;
		tick(2);
		resetn = 1'b1;
		tick(2);
	endtask

	task automatic run_len(input logic v, input int lim, output int k);
		k = 0;
		while (ck_oe === v && k < lim)
		begin
			tick(1);
			k++;
		end
	endtask

	task automatic wait_oe(input logic v);
		int k;
		run_len(~v, 300, k);
		if (k >= 300)
		begin
			chk_val("clock_wait", v, ck_oe);
			complete_run();
		end
	endtask

	function automatic int half(input int p);
		return (p * 16 + 49) / 50;
	endfunction

	function automatic logic filt(input int sel);
		case (sel)
			0: return md_f;
			1: return sc_f;
			default: return sd_f;
		endcase
	endfunction

	task automatic set_line(input int sel, input logic v);
		case (sel)
			0: md_in = v;
			1: sc_in = v;
			default: sd_in = v;
		endcase
	endtask

	task automatic filt_lat(input int sel, input int d);
		int  k;
		logic seen;
		if (d > 1)
		begin
			set_line(sel, 1'b0);
			tick(1);
			set_line(sel, 1'b1);
			seen = 1'b1;
			repeat (d + 2)
			begin
				tick(1);
				seen &= filt(sel);
			end
			chk_val("glitch_kept", 1, seen);
		end
		set_line(sel, 1'b0);
		k = 0;
		while (filt(sel) !== 1'b0 && k < 40)
		begin
			tick(1);
			k++;
		end
		chk_rng("filter_delay", (d > 1) ? d : 1, d + 1, k);
		set_line(sel, 1'b1);
		tick(d + 3);
	endtask

	initial
	begin
		resetn = 1'b0;
		slow = 1'b1;
		mode = 4'h1;
		addr = 4'ha;
		wr_en = 1'b0;
		wr_data = 32'h0;
		arb_lost = 1'b0;
		cksum_fail = 1'b0;
		md_in = 1'b1;
		sc_in = 1'b1;
		sd_in = 1'b1;
		failures = 0;
		num_checks = 0;
		// Straps and start-up for every switch mode
		for (int m = 0; m < 16; m++)
		begin
			do_reset(m[0], m[3:0], ~m[3:0]);
			chk_val("ctrl_reset", {16'h0, m[0] ? 16'h0139 : 16'h0053}, rd_data);
			chk_val("load_req", LOAD_MODES[m], load_req);
			chk_val("dev_addr", {3'b101, ~m[3:0]}, dev_addr);
			chk_val("byte_addr", 0, byte_addr);
		end
		// Full load from address zero
		do_reset(1'b1, 4'h1, 4'h0);
		n = 0;
		while (load_req === 1'b1 && n < 300)
		begin
			tick(1);
			n++;
		end
		chk_val("load_end", 0, load_req);
		chk_val("bytes_read", NB, byte_addr);
		// Register rows and override bits
		foreach (rows[i])
		begin
			wr(rows[i].wd);
			tick(1);
			chk_val("ctrl_read", rows[i].rd, rd_data);
			arb_lost = 1'b1;
			cksum_fail = 1'b1;
			tick(1);
			arb_lost = 1'b0;
			cksum_fail = 1'b0;
			chk_val("arb_abort", rows[i].ab, arb_abort);
			chk_val("cksum_err", rows[i].ce, cksum_err);
		end
		// Filter delay for each glitch code
		for (int c = 0; c < 4; c++)
		begin
			wr({10'h0, c[1:0], c[1:0], 2'b00, 16'h0053});
			tick(2);
			filt_lat(0, MD[c]);
			filt_lat(1, SD[c]);
			filt_lat(2, SD[c]);
		end
		// Clock phases and a prescale change in mid low phase
		wr(32'h0000_0053);
		wait_oe(1'b0);
		wait_oe(1'b1);
		n = 0;
		while (ck_oe === 1'b1 && n < 300)
		begin
			if (n == 5)
			begin
				wr_en = 1'b1;
				wr_data = 32'h0000_0010;
			end
			if (n == 6)
				wr_en = 1'b0;
			if (n == 25)
			begin
				chk_val("mclk_filt", 0, mc_f);
				chk_val("mclk_out", 0, ck_out);
			end
			tick(1);
			n++;
		end
		chk_rng("low_time", half(83), half(83), n);
		run_len(1'b0, 300, n);
		chk_rng("high_time", half(16), half(16) + 1, n);
		run_len(1'b1, 300, n);
		chk_rng("low_time_new", half(16), half(16), n);
		// Prescale zero and one stop the clock, written in low then in high phase
		for (int v = 0; v < 4; v++)
		begin
			wr(32'h0000_0010);
			wait_oe(!v[1]);
			wr({31'h0, v[0]});
			wait_oe(1'b0);
			run_len(1'b0, 100, n);
			chk_rng("clock_stop", 100, 100, n);
			chk_val("mclk_idle", 1, mc_f);
		end
		complete_run();
	end
endmodule
